/* File: rirq_pkg.sv */
// constants, field positions and state encodings shared by both ends
// assumes one clock and one synchronous reset for both ends
package rirq_pkg;

   // device register offsets on the link
   localparam logic [7:0] ADDR_QUEUE    = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h01;
   localparam logic [7:0] ADDR_CONFIG   = 8'h02;
   localparam logic [7:0] ADDR_COMMAND  = 8'h03;
   localparam logic [7:0] ADDR_BLANK    = 8'h04;
   localparam logic [7:0] ADDR_REVISION = 8'h1F;

   // device field positions
   localparam int ST_READY    = 0;
   localparam int ST_FAULT    = 1;
   localparam int CFG_RDY_PIN = 0;
   localparam int CFG_FLT_PIN = 1;
   localparam int CFG_DISCARD = 2;
   localparam int CMD_RETRY   = 0;

   // device reset values and fixed codes
   localparam logic [2:0] CONFIG_RESET = 3'h0;
   localparam logic [7:0] BLANK_RESET  = 8'h00;
   localparam logic [7:0] QUEUE_RESET  = 8'h00;
   // arbitrary revision value
   localparam logic [3:0] REV_CODE     = 4'h3;

   // thermal shutdown point in degrees Celsius
   localparam logic [8:0] THERM_SHDN_C = 9'h0A0;
   // least blanking time in ms that the host programs
   localparam logic [7:0] BLANK_MIN_MS = 8'h37;

   // host register byte offsets on Avalon-MM
   localparam logic [4:0] H_CTRL      = 5'h00;
   localparam logic [4:0] H_BLANK     = 5'h04;
   localparam logic [4:0] H_STATUS    = 5'h08;
   localparam logic [4:0] H_DATA      = 5'h0C;
   localparam logic [4:0] H_IRQ_STAT  = 5'h10;
   localparam logic [4:0] H_IRQ_CLEAR = 5'h14;
   localparam logic [4:0] H_IRQ_EN    = 5'h18;

   // host field positions
   localparam int CTRL_ENABLE  = 0;
   localparam int CTRL_RETRY   = 1;
   localparam int CTRL_RDY_PIN = 2;
   localparam int CTRL_FLT_PIN = 3;
   localparam int HST_INIT     = 0;
   localparam int HST_BUSY     = 1;
   localparam int HST_REV_LSB  = 8;
   localparam int HIRQ_MSG     = 0;
   localparam int HIRQ_FAULT   = 1;

   typedef enum logic [0:0] {
      RIRQ_RUN      = 1'b0,
      RIRQ_SHUTDOWN = 1'b1
   } rirq_therm_e;

   typedef enum logic [2:0] {
      RIRQ_H_OFF   = 3'b000,
      RIRQ_H_REV   = 3'b001,
      RIRQ_H_BLANK = 3'b010,
      RIRQ_H_CFG   = 3'b011,
      RIRQ_H_WAIT  = 3'b100,
      RIRQ_H_STAT  = 3'b101,
      RIRQ_H_QUEUE = 3'b110,
      RIRQ_H_RETRY = 3'b111
   } rirq_host_e;

endpackage

/* File: rirq_link_if.sv */
// register access and interrupt wires between host and device end
// assumes both ends run on the same clock
interface rirq_link_if;
   logic       req;
   logic       wr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       ack;
   logic       irq_n;
   logic       rdy_pin_n;
   logic       flt_pin_n;

   modport dev (
      input  req, wr, addr, wdata,
      output rdata, ack, irq_n, rdy_pin_n, flt_pin_n
   );

   modport host (
      output req, wr, addr, wdata,
      input  rdata, ack, irq_n, rdy_pin_n, flt_pin_n
   );
endinterface

/* File: rirq_device.sv */
// device end: receive events, interrupt pins and revision register
// assumes framer pulses on the same clock and a host that holds req
// until ack
//
// What this block does
// R1: revision read-only, upper nibble zero, fixed code
// R2: host reads revision only during initialisation
// R3: good response sets ready status and irq
// R4: good response drives ready pin when enabled
// R5: queue read clears ready status and pin
// R6: faulty or late response raises fault, irq
// R7: fault drives fault pin when enabled
// R8: optional discard of bad message, host retries
// R9: host steps in only when the device signals
// R10: thermal shutdown once temperature reaches threshold
// R11: host programs blanking time at least minimum
// R12: irq held while any source pending
module rirq_device
   import rirq_pkg::*;
(
   // clock, reset, enable
   input  wire logic       clk_sys_in,
   input  wire logic       rst_b_in,
   input  wire logic       ce_in,
   // framer events and die temperature
   input  wire logic       resp_done_in,
   input  wire logic [7:0] resp_byte_in,
   input  wire logic       resp_err_in,
   input  wire logic       resp_late_in,
   input  wire logic [8:0] die_temp_in,
   // user-side outputs
   output logic            retransmit_out,
   output logic            thermal_shutdown_out,
   output logic [7:0]      blank_time_out,
   // link to host
   rirq_link_if.dev        link
);
   import rirq_pkg::*;

   // bus group
   logic       ack;
   logic [7:0] rdata;
   logic       next_ack;
   logic [7:0] next_rdata;
   logic       take;
   logic       rd_queue;
   logic       rd_stat;
   logic       wr_cfg;
   logic       wr_cmd;
   logic       wr_blank;

   // status group
   logic       ready;
   logic       fault;
   logic [7:0] queue;
   logic [2:0] config_q;
   logic [7:0] blank;
   logic       retransmit;
   logic       irq_n;
   logic       rdy_pin_n;
   logic       flt_pin_n;
   logic       next_ready;
   logic       next_fault;
   logic [7:0] next_queue;
   logic [2:0] next_config;
   logic [7:0] next_blank;
   logic       next_retransmit;
   logic       next_irq_n;
   logic       next_rdy_pin_n;
   logic       next_flt_pin_n;
   logic       good_msg;
   logic       bad_msg;

   // thermal group
   rirq_therm_e therm;
   rirq_therm_e next_therm;
   logic        shdn;
   logic        next_shdn;

   // one access is taken per request; ack marks it
   always_comb begin
      take       = link.req && !ack;
      rd_queue   = take && !link.wr && (link.addr == ADDR_QUEUE);
      rd_stat    = take && !link.wr && (link.addr == ADDR_IRQ_STAT);
      wr_cfg     = take && link.wr && (link.addr == ADDR_CONFIG);
      wr_cmd     = take && link.wr && (link.addr == ADDR_COMMAND);
      wr_blank   = take && link.wr && (link.addr == ADDR_BLANK);
      next_ack   = take;
      next_rdata = rdata;
      if (take && !link.wr) begin
         case (link.addr)
            ADDR_QUEUE:    next_rdata = queue;
            ADDR_IRQ_STAT: next_rdata = {6'h00, fault, ready};
            ADDR_CONFIG:   next_rdata = {5'h00, config_q};
            ADDR_BLANK:    next_rdata = blank;
            // R1: fixed code, upper nibble zero
            ADDR_REVISION: next_rdata = {4'h0, REV_CODE};
            default:       next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         ack   <= 1'b0;
         rdata <= 8'h00;
      end else if (ce_in) begin
         ack   <= next_ack;
         rdata <= next_rdata;
      end
   end

   always_comb begin
      // a fault wins over a good message in the same cycle
      bad_msg         = (therm == RIRQ_RUN) && (resp_err_in || resp_late_in);
      good_msg        = (therm == RIRQ_RUN) && resp_done_in && !bad_msg;
      next_ready      = ready;
      next_fault      = fault;
      next_queue      = queue;
      next_config     = config_q;
      next_blank      = blank;
      next_retransmit = 1'b0;
      if (wr_cfg) begin
         next_config = link.wdata[2:0];
      end
      // R11: value stored as given; minimum is the host's duty
      if (wr_blank) begin
         next_blank = link.wdata;
      end
      // R8: host-managed resend of the master message
      if (wr_cmd && link.wdata[CMD_RETRY]) begin
         next_retransmit = 1'b1;
      end
      // R5: queue read clears ready
      if (rd_queue) begin
         next_ready = 1'b0;
      end
      // status read clears the fault; a new fault below wins
      if (rd_stat) begin
         next_fault = 1'b0;
      end
      // R8: discard the bad message when configured
      if (bad_msg && config_q[CFG_DISCARD]) begin
         next_ready = 1'b0;
         next_queue = QUEUE_RESET;
      end
      // R3: good response sets ready, set beats clear
      if (good_msg) begin
         next_ready = 1'b1;
         next_queue = resp_byte_in;
      end
      // R6: faulty or late response sets fault
      if (bad_msg) begin
         next_fault = 1'b1;
      end
      // R12: irq follows any pending source
      next_irq_n     = !(next_ready || next_fault);
      // R4: ready pin gated by its enable
      next_rdy_pin_n = !(next_ready && next_config[CFG_RDY_PIN]);
      // R7: fault pin gated by its enable
      next_flt_pin_n = !(next_fault && next_config[CFG_FLT_PIN]);
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         ready      <= 1'b0;
         fault      <= 1'b0;
         queue      <= QUEUE_RESET;
         config_q   <= CONFIG_RESET;
         blank      <= BLANK_RESET;
         retransmit <= 1'b0;
         irq_n      <= 1'b1;
         rdy_pin_n  <= 1'b1;
         flt_pin_n  <= 1'b1;
      end else if (ce_in) begin
         ready      <= next_ready;
         fault      <= next_fault;
         queue      <= next_queue;
         config_q   <= next_config;
         blank      <= next_blank;
         retransmit <= next_retransmit;
         irq_n      <= next_irq_n;
         rdy_pin_n  <= next_rdy_pin_n;
         flt_pin_n  <= next_flt_pin_n;
      end
   end

   // no hysteresis: leaves shutdown as soon as it cools below the point
   always_comb begin
      next_therm = therm;
      case (therm)
         // R10: enter shutdown at threshold
         RIRQ_RUN: begin
            if (die_temp_in >= THERM_SHDN_C) begin
               next_therm = RIRQ_SHUTDOWN;
            end
         end
         RIRQ_SHUTDOWN: begin
            if (die_temp_in < THERM_SHDN_C) begin
               next_therm = RIRQ_RUN;
            end
         end
         default: next_therm = RIRQ_RUN;
      endcase
      next_shdn = (next_therm == RIRQ_SHUTDOWN);
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         therm <= RIRQ_RUN;
         shdn  <= 1'b0;
      end else if (ce_in) begin
         therm <= next_therm;
         shdn  <= next_shdn;
      end
   end

   assign link.ack             = ack;
   assign link.rdata           = rdata;
   assign link.irq_n           = irq_n;
   assign link.rdy_pin_n       = rdy_pin_n;
   assign link.flt_pin_n       = flt_pin_n;
   assign retransmit_out       = retransmit;
   assign thermal_shutdown_out = shdn;
   assign blank_time_out       = blank;

endmodule

/* File: rirq_host.sv */
// host end: controller taking orders over Avalon-MM, serving device irq
// assumes the device end answers every request with ack
//
// Register access over Avalon-MM was left to the implementer.
module rirq_host
   import rirq_pkg::*;
(
   // clock, reset, enable
   input  wire logic        clk_sys_in,
   input  wire logic        rst_b_in,
   input  wire logic        ce_in,
   // Avalon-MM slave
   input  wire logic [4:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   output logic             irq_out,
   // link to device
   rirq_link_if.host        link
);
   import rirq_pkg::*;

   logic        wait_q;
   logic [31:0] rdata;
   logic [3:0]  ctrl;
   logic [7:0]  blank;
   logic [1:0]  irq_stat;
   logic [1:0]  irq_en;
   logic        irq;
   logic        next_wait;
   logic [31:0] next_rdata;
   logic [3:0]  next_ctrl;
   logic [7:0]  next_blank;
   logic [1:0]  next_irq_stat;
   logic [1:0]  next_irq_en;
   logic        next_irq;
   logic        acc;

   rirq_host_e  st;
   rirq_host_e  next_st;
   logic        req;
   logic        wr;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic [3:0]  rev;
   logic [7:0]  data;
   logic        init_done;
   logic        fault_seen;
   logic        next_req;
   logic        next_wr;
   logic [7:0]  next_addr;
   logic [7:0]  next_wdata;
   logic [3:0]  next_rev;
   logic [7:0]  next_data;
   logic        next_init;
   logic        next_fault_seen;
   logic [1:0]  ev;
   logic        done;

   // answer one cycle after the request, effects at the answer edge
   always_comb begin
      acc           = (avs_read_in || avs_write_in) && !wait_q;
      next_wait     = !((avs_read_in || avs_write_in) && wait_q);
      next_rdata    = rdata;
      next_ctrl     = ctrl;
      next_blank    = blank;
      next_irq_en   = irq_en;
      next_irq_stat = irq_stat;
      if (acc && avs_write_in) begin
         case (avs_address_in)
            H_CTRL:      next_ctrl = avs_writedata_in[3:0];
            H_BLANK:     next_blank = avs_writedata_in[7:0];
            H_IRQ_CLEAR: next_irq_stat = irq_stat & ~avs_writedata_in[1:0];
            H_IRQ_EN:    next_irq_en = avs_writedata_in[1:0];
            default:     next_irq_en = irq_en;
         endcase
      end
      // events set after the clear, so a set wins
      next_irq_stat = next_irq_stat | ev;
      if (avs_read_in && wait_q) begin
         case (avs_address_in)
            H_CTRL:     next_rdata = {28'h0000000, ctrl};
            H_BLANK:    next_rdata = {24'h000000, blank};
            H_STATUS:   next_rdata = {20'h00000, rev, 6'h00,
                                      st != RIRQ_H_WAIT, init_done};
            H_DATA:     next_rdata = {24'h000000, data};
            H_IRQ_STAT: next_rdata = {30'h00000000, irq_stat};
            H_IRQ_EN:   next_rdata = {30'h00000000, irq_en};
            default:    next_rdata = 32'h00000000;
         endcase
      end
      next_irq = |(next_irq_stat & next_irq_en);
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         wait_q   <= 1'b1;
         rdata    <= 32'h00000000;
         ctrl     <= 4'h0;
         blank    <= BLANK_MIN_MS;
         irq_stat <= 2'h0;
         irq_en   <= 2'h0;
         irq      <= 1'b0;
      end else if (ce_in) begin
         wait_q   <= next_wait;
         rdata    <= next_rdata;
         ctrl     <= next_ctrl;
         blank    <= next_blank;
         irq_stat <= next_irq_stat;
         irq_en   <= next_irq_en;
         irq      <= next_irq;
      end
   end

   always_comb begin
      done            = req && link.ack;
      next_st         = st;
      next_rev        = rev;
      next_data       = data;
      next_init       = init_done;
      next_fault_seen = fault_seen;
      ev              = 2'h0;
      case (st)
         RIRQ_H_OFF: begin
            next_init = 1'b0;
            if (ctrl[CTRL_ENABLE]) begin
               next_st = RIRQ_H_REV;
            end
         end
         // R2: revision read only during initialisation
         RIRQ_H_REV: begin
            if (done) begin
               next_rev = link.rdata[3:0];
               next_st  = RIRQ_H_BLANK;
            end
         end
         RIRQ_H_BLANK: begin
            if (done) begin
               next_st = RIRQ_H_CFG;
            end
         end
         RIRQ_H_CFG: begin
            if (done) begin
               next_init = 1'b1;
               next_st   = RIRQ_H_WAIT;
            end
         end
         // R9: act only when the device signals
         RIRQ_H_WAIT: begin
            if (!ctrl[CTRL_ENABLE]) begin
               next_st = RIRQ_H_OFF;
            end else if (!link.irq_n) begin
               next_st = RIRQ_H_STAT;
            end
         end
         RIRQ_H_STAT: begin
            if (done) begin
               next_fault_seen = link.rdata[ST_FAULT];
               ev[HIRQ_FAULT]  = link.rdata[ST_FAULT];
               if (link.rdata[ST_READY]) begin
                  next_st = RIRQ_H_QUEUE;
               end else if (link.rdata[ST_FAULT] && ctrl[CTRL_RETRY]) begin
                  next_st = RIRQ_H_RETRY;
               end else begin
                  next_st = RIRQ_H_WAIT;
               end
            end
         end
         RIRQ_H_QUEUE: begin
            if (done) begin
               next_data    = link.rdata;
               ev[HIRQ_MSG] = 1'b1;
               next_st      = (fault_seen && ctrl[CTRL_RETRY]) ?
                              RIRQ_H_RETRY : RIRQ_H_WAIT;
            end
         end
         // R8: host drives the resend
         RIRQ_H_RETRY: begin
            if (done) begin
               next_st = RIRQ_H_WAIT;
            end
         end
         default: next_st = RIRQ_H_OFF;
      endcase
      next_req   = 1'b1;
      next_wr    = 1'b0;
      next_addr  = 8'h00;
      next_wdata = 8'h00;
      case (next_st)
         RIRQ_H_REV:   next_addr = ADDR_REVISION;
         RIRQ_H_BLANK: begin
            next_wr    = 1'b1;
            next_addr  = ADDR_BLANK;
            // R11: never below the least blanking time
            next_wdata = (blank < BLANK_MIN_MS) ? BLANK_MIN_MS : blank;
         end
         RIRQ_H_CFG: begin
            next_wr    = 1'b1;
            next_addr  = ADDR_CONFIG;
            next_wdata = {5'h00, ctrl[CTRL_RETRY], ctrl[CTRL_FLT_PIN],
                          ctrl[CTRL_RDY_PIN]};
         end
         RIRQ_H_STAT:  next_addr = ADDR_IRQ_STAT;
         RIRQ_H_QUEUE: next_addr = ADDR_QUEUE;
         RIRQ_H_RETRY: begin
            next_wr    = 1'b1;
            next_addr  = ADDR_COMMAND;
            next_wdata = 8'h01;
         end
         default:      next_req = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         st         <= RIRQ_H_OFF;
         req        <= 1'b0;
         wr         <= 1'b0;
         addr       <= 8'h00;
         wdata      <= 8'h00;
         rev        <= 4'h0;
         data       <= 8'h00;
         init_done  <= 1'b0;
         fault_seen <= 1'b0;
      end else if (ce_in) begin
         st         <= next_st;
         req        <= next_req;
         wr         <= next_wr;
         addr       <= next_addr;
         wdata      <= next_wdata;
         rev        <= next_rev;
         data       <= next_data;
         init_done  <= next_init;
         fault_seen <= next_fault_seen;
      end
   end

   assign link.req            = req;
   assign link.wr             = wr;
   assign link.addr           = addr;
   assign link.wdata          = wdata;
   assign avs_readdata_out    = rdata;
   assign avs_waitrequest_out = wait_q;
   assign irq_out             = irq;

endmodule

/* File: rirq_link_sva.sv */
// checker watching the link between host end and device end
// assumes one clock; signals taken straight off the link interface
module rirq_link_sva
   import rirq_pkg::*;
(
   // clock and reset
   input wire logic       clk_sys_in,
   input wire logic       rst_b_in,
   // link signals
   input wire logic       req,
   input wire logic       wr,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic       ack,
   input wire logic       irq_n,
   input wire logic       rdy_pin_n,
   input wire logic       flt_pin_n
);
   timeunit 1ns;
   timeprecision 1ns;

   logic rev_done;
   logic next_rev_done;

   // remembers that the revision was already fetched once
   always_comb begin
      next_rev_done = rev_done | (ack & ~wr & (addr == ADDR_REVISION));
   end

   always_ff @(posedge clk_sys_in) begin
      rev_done <= rst_b_in ? next_rev_done : 1'b0;
   end

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_b_in);

   rev_read_code_a: assert property (
      req && !ack && !wr && addr == ADDR_REVISION
      |=> ack && rdata == {4'h0, REV_CODE})
      else $error("revision read gave wrong value");
   answer_next_a: assert property (req && !ack |=> ack)
      else $error("link request not answered next cycle");
   ack_pulse_a: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   req_hold_a: assert property (req && !ack |=> req && $stable(addr)
      && $stable(wr) && $stable(wdata))
      else $error("link request changed before ack");
   write_rdata_a: assert property (ack && wr |-> $stable(rdata))
      else $error("read data changed on a write");
   rdy_pin_irq_a: assert property (!rdy_pin_n |-> !irq_n)
      else $error("ready pin low without irq");
   flt_pin_irq_a: assert property (!flt_pin_n |-> !irq_n)
      else $error("fault pin low without irq");
   irq_release_a: assert property ($rose(irq_n) |-> ack && !wr)
      else $error("irq released without a read");
   flt_release_a: assert property ($rose(flt_pin_n) |-> ack)
      else $error("fault pin released without access");
   blank_min_a: assert property (
      req && wr && addr == ADDR_BLANK |-> wdata >= BLANK_MIN_MS)
      else $error("blanking time below minimum");
   rev_once_a: assert property (
      rev_done |-> !(req && !wr && addr == ADDR_REVISION))
      else $error("revision read after initialisation");
endmodule

/* File: tb.sv */
// self-checking bench: host and device ends joined by the link
// assumes Avalon-MM master behaviour and framer pulses from the bench
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import rirq_pkg::*;

   logic        clk_sys_in = 1'b0, rst_b_in = 1'b0, ce_in = 1'b1;
   logic        resp_done_in = 1'b0, resp_err_in = 1'b0;
   logic        resp_late_in = 1'b0;
   logic [7:0]  resp_byte_in = 8'h00;
   logic [8:0]  die_temp_in = 9'h019;
   logic [4:0]  avs_address_in = 5'h00;
   logic        avs_read_in = 1'b0, avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
   logic        avs_waitrequest_out, irq_out;
   logic        retransmit_out, thermal_shutdown_out;
   logic [7:0]  blank_time_out, bl;
   logic        rdy_seen = 1'b0, flt_seen = 1'b0;
   int          num_errors = 0, n_compared = 0, n_retx = 0, k;

   always #20 clk_sys_in = ~clk_sys_in;

   rirq_link_if u_rirq_link_if ();
   rirq_device u_rirq_device (.clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in), .ce_in(ce_in), .resp_done_in(resp_done_in),
      .resp_byte_in(resp_byte_in), .resp_err_in(resp_err_in),
      .resp_late_in(resp_late_in), .die_temp_in(die_temp_in),
      .retransmit_out(retransmit_out),
      .thermal_shutdown_out(thermal_shutdown_out),
      .blank_time_out(blank_time_out), .link(u_rirq_link_if));
   rirq_host u_rirq_host (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
      .ce_in(ce_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in),
      .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
      .link(u_rirq_link_if));
   rirq_link_sva u_rirq_link_sva (.clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in), .req(u_rirq_link_if.req),
      .wr(u_rirq_link_if.wr), .addr(u_rirq_link_if.addr),
      .wdata(u_rirq_link_if.wdata), .rdata(u_rirq_link_if.rdata),
      .ack(u_rirq_link_if.ack), .irq_n(u_rirq_link_if.irq_n),
      .rdy_pin_n(u_rirq_link_if.rdy_pin_n),
      .flt_pin_n(u_rirq_link_if.flt_pin_n));

   always @(posedge clk_sys_in) begin
      if (u_rirq_link_if.rdy_pin_n === 1'b0) rdy_seen <= 1'b1;
      if (u_rirq_link_if.flt_pin_n === 1'b0) flt_seen <= 1'b1;
      if (retransmit_out === 1'b1) n_retx <= n_retx + 1;
   end

   task automatic test_done;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, exp, input string m);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask

   // request held until the edge where waitrequest is seen low
   task automatic av(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
      int i;
      @(posedge clk_sys_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= w;
      avs_read_in <= !w;
      i = 0;
      // waitrequest and read data are looked at on the rising edge
      do begin
         @(posedge clk_sys_in);
         i++;
      end while (avs_waitrequest_out !== 1'b0 && i < 200);
      if (avs_waitrequest_out !== 1'b0) begin
         num_errors++;
         test_done();
      end
      q = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask

   task automatic wait_irq;
      int i;
      for (i = 0; i < 300 && irq_out !== 1'b1; i++) idle(1);
      if (i >= 300) begin
         num_errors++;
         test_done();
      end
   endtask

   // kind 0 good, 1 faulty, 2 late, 3 good and faulty together
   task automatic pulse(input int kind, input logic [7:0] b);
      @(posedge clk_sys_in);
      resp_done_in <= (kind == 0 || kind == 3);
      resp_err_in <= (kind == 1 || kind == 3);
      resp_late_in <= (kind == 2);
      resp_byte_in <= b;
      @(posedge clk_sys_in);
      resp_done_in <= 1'b0;
      resp_err_in <= 1'b0;
      resp_late_in <= 1'b0;
   endtask

   function automatic logic [31:0] exp_irq(input int kind);
      return (kind == 0) ? 32'h1 << HIRQ_MSG : 32'h1 << HIRQ_FAULT;
   endfunction

   function automatic logic [7:0] exp_blank(input logic [7:0] v);
      return (v < BLANK_MIN_MS) ? BLANK_MIN_MS : v;
   endfunction

   task automatic run_event(input int kind);
      logic [7:0] b;
      int         r0;
      b = 8'($urandom);
      r0 = n_retx;
      rdy_seen = 1'b0;
      flt_seen = 1'b0;
      pulse(kind, b);
      wait_irq();
      idle(10);
      av(1'b0, H_IRQ_STAT, 32'h0);
      check(q, exp_irq(kind), "irq status");
      check(32'(rdy_seen), 32'(kind == 0), "ready pin");
      check(32'(flt_seen), 32'(kind != 0), "fault pin");
      if (kind == 0) begin
         av(1'b0, H_DATA, 32'h0);
         check(q, {24'h0, b}, "queue byte");
      end
      check(32'(n_retx - r0), 32'(kind != 0), "retransmit");
      av(1'b1, H_IRQ_CLEAR, 32'h3);
      idle(2);
      check(32'({irq_out, u_rirq_link_if.irq_n, u_rirq_link_if.rdy_pin_n,
             u_rirq_link_if.flt_pin_n}), 32'h7, "cleared");
   endtask

   initial begin
      void'($urandom(32'h8775db08));
      repeat (16) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      av(1'b0, H_BLANK, 32'h0);
      check(q, 32'(BLANK_MIN_MS), "blank reset");
      av(1'b0, H_IRQ_EN, 32'h0);
      check(q, 32'h0, "enable reset");
      av(1'b0, 5'h1C, 32'h0);
      check(q, 32'h0, "unmapped read");
      av(1'b1, H_IRQ_STAT, 32'h3);
      av(1'b0, H_IRQ_STAT, 32'h0);
      check(q, 32'h0, "status read only");
      bl = 8'($urandom_range(0, 120));
      av(1'b1, H_BLANK, {24'h0, bl});
      av(1'b1, H_IRQ_EN, 32'h3);
      av(1'b1, H_CTRL, 32'hF);
      for (k = 0; k < 50 && q[HST_INIT] !== 1'b1; k++)
         av(1'b0, H_STATUS, 32'h0);
      check(32'(q[HST_INIT]), 32'h1, "init done");
      check(32'(q[11:8]), 32'(REV_CODE), "revision");
      check(32'(blank_time_out), 32'(exp_blank(bl)), "blank");
      run_event(3);
      run_event(0);
      for (k = 0; k < 16; k++) run_event($urandom_range(0, 3));
      av(1'b1, H_IRQ_EN, 32'h0);
      pulse(0, 8'h5A);
      idle(40);
      check(32'(irq_out), 32'h0, "masked irq");
      av(1'b0, H_IRQ_STAT, 32'h0);
      check(q, exp_irq(0), "masked status");
      av(1'b1, H_IRQ_EN, 32'h3);
      idle(2);
      check(32'(irq_out), 32'h1, "unmasked irq");
      av(1'b1, H_IRQ_CLEAR, 32'h3);
      // a frozen block misses the event instead of holding it
      ce_in <= 1'b0;
      pulse(0, 8'h3C);
      idle(3);
      ce_in <= 1'b1;
      idle(40);
      av(1'b0, H_IRQ_STAT, 32'h0);
      check(q, 32'h0, "frozen event");
      die_temp_in <= 9'h09F;
      idle(3);
      check(32'(thermal_shutdown_out), 32'h0, "below limit");
      die_temp_in <= THERM_SHDN_C;
      idle(3);
      check(32'(thermal_shutdown_out), 32'h1, "shutdown");
      pulse(0, 8'hA5);
      idle(40);
      av(1'b0, H_IRQ_STAT, 32'h0);
      check(q, 32'h0, "events ignored");
      die_temp_in <= 9'h019;
      idle(3);
      check(32'(thermal_shutdown_out), 32'h0, "recovered");
      test_done();
   end
endmodule
